// ==== shared/bsp_pkg.sv ====
`default_nettype none

package bsp_pkg;

  localparam int IR_LEN    = 5;
  localparam int ID_LEN    = 32;
  localparam int SYS_PINS  = 4;
  localparam int BSR_LEN   = 3 * SYS_PINS;
  localparam int TEST_PINS = 4;

  // Boundary cell groups inside the scan chain
  localparam int BSR_IN_LO  = 0;
  localparam int BSR_OUT_LO = SYS_PINS;
  localparam int BSR_OE_LO  = 2 * SYS_PINS;

  // Test pin positions on the shared pin bus
  localparam int PIN_TCK = 0;
  localparam int PIN_TMS = 1;
  localparam int PIN_TDI = 2;
  localparam int PIN_TDO = 3;

  // Instruction codes
  localparam logic [IR_LEN-1:0] INS_EXTEST = 5'h00;
  localparam logic [IR_LEN-1:0] INS_IDCODE = 5'h01;
  localparam logic [IR_LEN-1:0] INS_SAMPLE = 5'h02;
  localparam logic [IR_LEN-1:0] INS_INTEST = 5'h03;
  localparam logic [IR_LEN-1:0] INS_HIGHZ  = 5'h05;
  localparam logic [IR_LEN-1:0] INS_BYPASS = 5'h1F;

  // Fixed pattern loaded by instruction capture
  localparam logic [IR_LEN-1:0] IR_CAPTURE = 5'h01;

  // Arbitrary identification value, not tied to any real part
  localparam logic [ID_LEN-1:0] ID_DEFAULT = 32'h0A5C_3001;

  typedef enum logic [3:0] {
    TAP_RESET,
    TAP_IDLE,
    TAP_SEL_DR,
    TAP_CAP_DR,
    TAP_SHIFT_DR,
    TAP_EXIT1_DR,
    TAP_PAUSE_DR,
    TAP_EXIT2_DR,
    TAP_UPD_DR,
    TAP_SEL_IR,
    TAP_CAP_IR,
    TAP_SHIFT_IR,
    TAP_EXIT1_IR,
    TAP_PAUSE_IR,
    TAP_EXIT2_IR,
    TAP_UPD_IR
  } bsp_tap_state_type;

endpackage

`default_nettype wire

// ==== shared/bsp_tap_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface bsp_tap_if;
  import bsp_pkg::*;

  logic              rise;
  logic              tms;
  logic              hold;
  bsp_tap_state_type state;

  modport ctrl (
    input  rise,
    input  tms,
    input  hold,
    output state
  );

  modport core (
    output rise,
    output tms,
    output hold,
    input  state
  );

endinterface

`default_nettype wire

// ==== core/bsp_tap_fsm.sv ====
`timescale 1ns/1ps
`default_nettype none

module bsp_tap_fsm
  import bsp_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  bsp_tap_if.ctrl  tap
);

  bsp_tap_state_type state;
  bsp_tap_state_type next_state;

  // Sixteen-state controller, steps on test clock rising edges; hold forces it to reset without an edge
  always_comb begin
    next_state = state;
    if (tap.hold) begin
      next_state = TAP_RESET; // see (R14)
    end else if (tap.rise) begin
      unique case (state) // see (R19)
        TAP_RESET:    next_state = tap.tms ? TAP_RESET    : TAP_IDLE;
        TAP_IDLE:     next_state = tap.tms ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_DR:   next_state = tap.tms ? TAP_SEL_IR   : TAP_CAP_DR;
        TAP_CAP_DR:   next_state = tap.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: next_state = tap.tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: next_state = tap.tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
        TAP_PAUSE_DR: next_state = tap.tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: next_state = tap.tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
        TAP_UPD_DR:   next_state = tap.tms ? TAP_SEL_DR   : TAP_IDLE;
        TAP_SEL_IR:   next_state = tap.tms ? TAP_RESET    : TAP_CAP_IR;
        TAP_CAP_IR:   next_state = tap.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: next_state = tap.tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: next_state = tap.tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
        TAP_PAUSE_IR: next_state = tap.tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: next_state = tap.tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
        TAP_UPD_IR:   next_state = tap.tms ? TAP_SEL_DR   : TAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= TAP_RESET; // see (R9)
    end else begin
      state <= next_state;
    end
  end

  assign tap.state = state;

  hold_reset_a: assert property ( // see (R14)
    @(posedge mclk_i) disable iff (rst_i)
    tap.hold |=> state == TAP_RESET)
    else $error("controller not parked while port disabled");

  no_edge_stable_a: assert property ( // see (R19)
    @(posedge mclk_i) disable iff (rst_i)
    !tap.rise && !tap.hold |=> $stable(state))
    else $error("controller moved without a test clock edge");

  sel_ir_exit_a: assert property ( // see (R19)
    @(posedge mclk_i) disable iff (rst_i)
    state == TAP_SEL_IR && tap.rise && tap.tms && !tap.hold
      |=> state == TAP_RESET)
    else $error("high mode select in select-ir did not reset");

  shift_stay_a: assert property ( // see (R19)
    @(posedge mclk_i) disable iff (rst_i)
    state == TAP_SHIFT_DR && tap.rise && !tap.tms && !tap.hold
      |=> state == TAP_SHIFT_DR)
    else $error("shift state left with low mode select");

endmodule

`default_nettype wire

// ==== core/bsp_tap_port.sv ====
// Behaviour
// (R1) Code 00010 selects boundary chain; captures pins, update loads latches.
// (R2) Code 00000 drives latched boundary values onto system pins.
// (R3) Code 11111 puts one-bit bypass between data in and out.
// (R4) Controller may load all-ones by holding data in high.
// (R5) Code 00001 shifts identification value out serially.
// (R6) Code 00101 floats all system outputs and selects bypass.
// (R7) Code 00011 selects boundary chain to drive core inputs.
// (R8) Port uses clock, mode, data in, data out only; no test reset.
// (R9) Power-up reset initialises the test logic.
// (R10) Port enable high returns four pins to test function.
// (R11) Port enable low restores four pins to user function.
// (R12) System holds port enable low through power-up.
// (R13) Unprogrammed part has the four pins working as test port.
// (R14) Pins in user role with enable low ignore test activity.
// (R15) Macrocells behind test pins stay usable as buried logic.
// (R16) Data in sampled on each rising test clock edge.
// (R17) Data out changes on falling edge, floats when not shifting.
// (R18) Controller keeps mode select high during normal operation.
// (R19) Standard sixteen-state controller sequences 5-bit instruction and data.
// (R20) Unassigned instruction codes select the bypass register.
`timescale 1ns/1ps
`default_nettype none

module bsp_tap_port
  import bsp_pkg::*;
#(
  parameter logic [ID_LEN-1:0] ID_VALUE = ID_DEFAULT
) (
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 port_en_i,
  input  wire logic                 pins_user_i,
  input  wire logic [TEST_PINS-1:0] pin_in_i,
  output logic      [TEST_PINS-1:0] pin_out_o,
  output logic      [TEST_PINS-1:0] pin_oe_o,
  input  wire logic [TEST_PINS-1:0] user_out_i,
  input  wire logic [TEST_PINS-1:0] user_oe_i,
  output logic      [TEST_PINS-1:0] user_in_o,
  output logic      [TEST_PINS-1:0] user_fb_o,
  input  wire logic [SYS_PINS-1:0]  sys_in_i,
  input  wire logic [SYS_PINS-1:0]  core_out_i,
  input  wire logic [SYS_PINS-1:0]  core_oe_i,
  output logic      [SYS_PINS-1:0]  sys_out_o,
  output logic      [SYS_PINS-1:0]  sys_oe_o,
  output logic      [SYS_PINS-1:0]  core_in_o,
  output logic                      test_active_o,
  output logic      [IR_LEN-1:0]    instr_o
);

  bsp_tap_if tap ();

  // Input synchronisers
  logic                 pe_meta;
  logic                 pe_sync;
  logic [TEST_PINS-1:0] pin_meta;
  logic [TEST_PINS-1:0] pin_sync;
  logic [SYS_PINS-1:0]  sys_meta;
  logic [SYS_PINS-1:0]  sys_sync;
  logic                 tck_prev;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pe_meta  <= 1'b0;
      pe_sync  <= 1'b0;
      pin_meta <= '0;
      pin_sync <= '0;
      sys_meta <= '0;
      sys_sync <= '0;
      tck_prev <= 1'b0;
    end else begin
      pe_meta  <= port_en_i;
      pe_sync  <= pe_meta;
      pin_meta <= pin_in_i;
      pin_sync <= pin_meta;
      sys_meta <= sys_in_i;
      sys_sync <= sys_meta;
      tck_prev <= pin_sync[PIN_TCK];
    end
  end

  // Test clock edges and pin roles
  logic rise;
  logic fall;
  logic tdi;
  logic port_en;
  logic hold;

  assign rise    = pin_sync[PIN_TCK] & ~tck_prev; // see (R8)
  assign fall    = ~pin_sync[PIN_TCK] & tck_prev;
  assign tdi     = pin_sync[PIN_TDI];
  // Pins serve test unless the design claimed them and enable is low
  assign port_en = pe_sync | ~pins_user_i; // see (R10) see (R11) see (R13)
  assign hold    = ~port_en; // see (R14)

  assign tap.rise = rise;
  assign tap.tms  = pin_sync[PIN_TMS];
  assign tap.hold = hold;

  bsp_tap_fsm u_fsm (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .tap    (tap)
  );

  // Instruction decode
  logic [IR_LEN-1:0] ir;
  logic              sel_bsr;
  logic              sel_id;
  logic              shifting;

  assign sel_bsr  = (ir == INS_EXTEST) || (ir == INS_SAMPLE)
                 || (ir == INS_INTEST); // see (R1) see (R2) see (R7)
  assign sel_id   = (ir == INS_IDCODE); // see (R5)
  // Any other code, all-ones and high-z included, uses bypass
  assign shifting = (tap.state == TAP_SHIFT_DR)
                 || (tap.state == TAP_SHIFT_IR);

  // Scan registers
  logic [IR_LEN-1:0]  ir_sr;
  logic [BSR_LEN-1:0] bsr_sr;
  logic [BSR_LEN-1:0] bsr_upd;
  logic [ID_LEN-1:0]  id_sr;
  logic               byp;
  logic               tdo;
  logic               tdo_oe;
  logic [IR_LEN-1:0]  next_ir;
  logic [IR_LEN-1:0]  next_ir_sr;
  logic [BSR_LEN-1:0] next_bsr_sr;
  logic [BSR_LEN-1:0] next_bsr_upd;
  logic [ID_LEN-1:0]  next_id_sr;
  logic               next_byp;
  logic               next_tdo;
  logic               next_tdo_oe;
  logic [BSR_LEN-1:0] bsr_capture;

  assign bsr_capture = {core_oe_i, core_out_i, sys_sync};

  always_comb begin
    next_ir      = ir;
    next_ir_sr   = ir_sr;
    next_bsr_sr  = bsr_sr;
    next_bsr_upd = bsr_upd;
    next_id_sr   = id_sr;
    next_byp     = byp;
    next_tdo     = tdo;
    next_tdo_oe  = tdo_oe;
    if (hold) begin
      next_ir     = INS_IDCODE; // see (R14)
      next_tdo_oe = 1'b0;
    end else begin
      if (tap.state == TAP_RESET) begin
        next_ir = INS_IDCODE;
      end
      if (rise) begin
        if (tap.state == TAP_CAP_IR) begin
          next_ir_sr = IR_CAPTURE; // see (R19)
        end else if (tap.state == TAP_SHIFT_IR) begin
          next_ir_sr = {tdi, ir_sr[IR_LEN-1:1]}; // see (R16) see (R4)
        end else if (tap.state == TAP_CAP_DR) begin
          if (sel_bsr) begin
            next_bsr_sr = bsr_capture; // see (R1)
          end else if (sel_id) begin
            next_id_sr = ID_VALUE; // see (R5)
          end else begin
            next_byp = 1'b0; // see (R3) see (R6) see (R20)
          end
        end else if (tap.state == TAP_SHIFT_DR) begin
          if (sel_bsr) begin
            next_bsr_sr = {tdi, bsr_sr[BSR_LEN-1:1]}; // see (R16)
          end else if (sel_id) begin
            next_id_sr = {tdi, id_sr[ID_LEN-1:1]}; // see (R5)
          end else begin
            next_byp = tdi; // see (R3)
          end
        end
      end
      if (fall) begin
        next_tdo_oe = shifting; // see (R17)
        if (tap.state == TAP_SHIFT_IR) begin
          next_tdo = ir_sr[0];
        end else if (tap.state == TAP_SHIFT_DR) begin
          if (sel_bsr) begin
            next_tdo = bsr_sr[0];
          end else if (sel_id) begin
            next_tdo = id_sr[0];
          end else begin
            next_tdo = byp;
          end
        end
        if (tap.state == TAP_UPD_IR) begin
          next_ir = ir_sr; // see (R19)
        end else if (tap.state == TAP_UPD_DR && sel_bsr) begin
          next_bsr_upd = bsr_sr; // see (R1)
        end
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ir      <= INS_IDCODE; // see (R9)
      ir_sr   <= '0;
      bsr_sr  <= '0;
      bsr_upd <= '0;
      id_sr   <= '0;
      byp     <= 1'b0;
      tdo     <= 1'b0;
      tdo_oe  <= 1'b0;
    end else begin
      ir      <= next_ir;
      ir_sr   <= next_ir_sr;
      bsr_sr  <= next_bsr_sr;
      bsr_upd <= next_bsr_upd;
      id_sr   <= next_id_sr;
      byp     <= next_byp;
      tdo     <= next_tdo;
      tdo_oe  <= next_tdo_oe;
    end
  end

  // Boundary latch fields
  logic [SYS_PINS-1:0] upd_in;
  logic [SYS_PINS-1:0] upd_out;
  logic [SYS_PINS-1:0] upd_oe;

  assign upd_in  = bsr_upd[BSR_IN_LO +: SYS_PINS];
  assign upd_out = bsr_upd[BSR_OUT_LO +: SYS_PINS];
  assign upd_oe  = bsr_upd[BSR_OE_LO +: SYS_PINS];

  // Output stage
  logic [TEST_PINS-1:0] next_pin_out;
  logic [TEST_PINS-1:0] next_pin_oe;
  logic [TEST_PINS-1:0] next_user_in;
  logic [SYS_PINS-1:0]  next_sys_out;
  logic [SYS_PINS-1:0]  next_sys_oe;
  logic [SYS_PINS-1:0]  next_core_in;

  always_comb begin
    next_pin_out = user_out_i; // see (R11)
    next_pin_oe  = user_oe_i;
    next_user_in = pin_sync;
    if (port_en) begin
      next_pin_out          = '0; // see (R10)
      next_pin_oe           = '0;
      next_user_in          = '0;
      next_pin_out[PIN_TDO] = next_tdo;
      next_pin_oe[PIN_TDO]  = next_tdo_oe; // see (R17)
    end
    next_sys_out = core_out_i;
    next_sys_oe  = core_oe_i;
    next_core_in = sys_sync;
    if (ir == INS_EXTEST || ir == INS_INTEST) begin
      next_sys_out = upd_out; // see (R2)
      next_sys_oe  = upd_oe;
    end
    if (ir == INS_INTEST) begin
      next_core_in = upd_in; // see (R7)
    end
    if (ir == INS_HIGHZ) begin
      next_sys_oe = '0; // see (R6)
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_out_o     <= '0;
      pin_oe_o      <= '0;
      user_in_o     <= '0;
      user_fb_o     <= '0;
      sys_out_o     <= '0;
      sys_oe_o      <= '0;
      core_in_o     <= '0;
      test_active_o <= 1'b0;
      instr_o       <= INS_IDCODE;
    end else begin
      pin_out_o     <= next_pin_out;
      pin_oe_o      <= next_pin_oe;
      user_in_o     <= next_user_in;
      user_fb_o     <= user_out_i; // see (R15)
      sys_out_o     <= next_sys_out;
      sys_oe_o      <= next_sys_oe;
      core_in_o     <= next_core_in;
      test_active_o <= port_en;
      instr_o       <= next_ir;
    end
  end

  // Checks
  tdo_drive_a: assert property ( // see (R17)
    @(posedge mclk_i) disable iff (rst_i)
    fall && !hold && shifting |=> pin_oe_o[PIN_TDO] && tdo_oe)
    else $error("data out not driven while shifting");

  tdo_float_a: assert property ( // see (R17)
    @(posedge mclk_i) disable iff (rst_i)
    fall && !hold && !shifting |=> !pin_oe_o[PIN_TDO])
    else $error("data out driven outside shift");

  user_pins_a: assert property ( // see (R11)
    @(posedge mclk_i) disable iff (rst_i)
    !port_en |=> pin_oe_o == $past(user_oe_i)
      && pin_out_o == $past(user_out_i))
    else $error("user pins not restored");

  highz_float_a: assert property ( // see (R6)
    @(posedge mclk_i) disable iff (rst_i)
    ir == INS_HIGHZ |=> sys_oe_o == '0)
    else $error("system outputs not floated");

  extest_drive_a: assert property ( // see (R2)
    @(posedge mclk_i) disable iff (rst_i)
    ir == INS_EXTEST |=> sys_out_o == $past(upd_out)
      && sys_oe_o == $past(upd_oe))
    else $error("latched boundary values not on pins");

  intest_core_a: assert property ( // see (R7)
    @(posedge mclk_i) disable iff (rst_i)
    ir == INS_INTEST |=> core_in_o == $past(upd_in))
    else $error("core inputs not from boundary latches");

  sample_cap_a: assert property ( // see (R1)
    @(posedge mclk_i) disable iff (rst_i)
    rise && !hold && sel_bsr && tap.state == TAP_CAP_DR
      |=> bsr_sr == $past(bsr_capture))
    else $error("boundary snapshot not captured");

  id_load_a: assert property ( // see (R5)
    @(posedge mclk_i) disable iff (rst_i)
    rise && !hold && sel_id && tap.state == TAP_CAP_DR
      |=> id_sr == ID_VALUE)
    else $error("identification value not captured");

  ir_update_a: assert property ( // see (R19)
    @(posedge mclk_i) disable iff (rst_i)
    fall && !hold && tap.state == TAP_UPD_IR |=> ir == $past(ir_sr))
    else $error("instruction not updated");

  bypass_cap_a: assert property ( // see (R20)
    @(posedge mclk_i) disable iff (rst_i)
    rise && !hold && !sel_bsr && !sel_id && tap.state == TAP_CAP_DR
      |=> byp == 1'b0)
    else $error("bypass cell not cleared on capture");

  id_shift_c: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    sel_id && fall && tap.state == TAP_SHIFT_DR);

  highz_c: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    ir == INS_HIGHZ && fall && tap.state == TAP_SHIFT_DR);

  extest_c: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    ir == INS_EXTEST && bsr_upd != '0);

  reclaim_c: cover property (
    @(posedge mclk_i) disable iff (rst_i)
    pins_user_i && $rose(pe_sync));

endmodule

`default_nettype wire

// ==== testbench/bsp_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module bsp_ctrl_model (
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);

  // Clock parked low outside frames, mode and data parked high
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // One test clock period of 320 ns; data out taken before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #160;
    tdo = tdo_i;
    tck_o = 1'b1;
    #160;
    tck_o = 1'b0;
  endtask

  // Five mode-high clocks, then into idle
  task automatic reset_tap;
    logic d;
    #13;
    repeat (5) step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
    tms_o = 1'b1;
  endtask

  // Idle to idle scan, shifting LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic d;
    #13;
    dout = '0;
    step(1'b1, 1'b1, d);
    if (ir) begin
      step(1'b1, 1'b1, d);
    end
    step(1'b0, 1'b1, d);
    step(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
    tms_o = 1'b1;
    tdi_o = 1'b1;
  endtask

endmodule

`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench
  import bsp_pkg::*;
;
  logic        mclk;
  logic        rst;
  logic        port_en;
  logic        pins_user;
  logic [3:0]  user_out;
  logic [3:0]  user_oe;
  logic [3:0]  sys_in;
  logic [3:0]  core_out;
  logic [3:0]  core_oe;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic [3:0]  user_in;
  logic [3:0]  user_fb;
  logic [3:0]  sys_out;
  logic [3:0]  sys_oe;
  logic [3:0]  core_in;
  logic        test_active;
  logic [4:0]  instr;
  logic [3:0]  pad;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic [31:0] d;
  int          error_cnt;
  int          checks_done;

  // Pads: device drive wins, else controller, data out pulled up
  assign pad = (pin_oe & pin_out) | (~pin_oe & {1'b1, tdi, tms, tck});

  always #20 mclk = ~mclk;

  bsp_tap_port bsp_tap_port_i (
    .mclk_i        (mclk),
    .rst_i         (rst),
    .port_en_i     (port_en),
    .pins_user_i   (pins_user),
    .pin_in_i      (pad),
    .pin_out_o     (pin_out),
    .pin_oe_o      (pin_oe),
    .user_out_i    (user_out),
    .user_oe_i     (user_oe),
    .user_in_o     (user_in),
    .user_fb_o     (user_fb),
    .sys_in_i      (sys_in),
    .core_out_i    (core_out),
    .core_oe_i     (core_oe),
    .sys_out_o     (sys_out),
    .sys_oe_o      (sys_oe),
    .core_in_o     (core_in),
    .test_active_o (test_active),
    .instr_o       (instr)
  );

  bsp_ctrl_model bsp_ctrl_model_i (
    .tdo_i (pad[3]),
    .tck_o (tck),
    .tms_o (tms),
    .tdi_o (tdi)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic settle;
    repeat (6) @(posedge mclk);
  endtask

  task automatic load_ir(input logic [4:0] code);
    bsp_ctrl_model_i.scan(1'b1, 5, 32'(code), d);
    settle;
    check(32'(d[4:0]), 32'(IR_CAPTURE));
  endtask

  task automatic t_reset;
    check(32'(instr), 32'(INS_IDCODE));
    check(32'(test_active), 32'h1);
    check(32'(pin_oe), 32'h0);
  endtask

  task automatic t_idcode;
    bsp_ctrl_model_i.reset_tap;
    bsp_ctrl_model_i.scan(1'b0, 32, 32'h0, d);
    settle;
    check(d, ID_DEFAULT);
    check(32'(pin_oe[3]), 32'h0);
  endtask

  task automatic t_codes;
    logic [4:0] codes [7];
    codes = '{INS_EXTEST, INS_IDCODE, INS_SAMPLE, INS_INTEST, INS_HIGHZ,
              INS_BYPASS, 5'h07};
    @(posedge mclk);
    core_out <= 4'h5;
    core_oe <= 4'hF;
    foreach (codes[i]) begin
      load_ir(codes[i]);
      check(32'(instr), 32'(codes[i]));
      if (codes[i] inside {INS_HIGHZ, INS_BYPASS, 5'h07}) begin
        bsp_ctrl_model_i.scan(1'b0, 8, 32'hB5, d);
        check(32'(d[7:0]), 32'h6A);
        check(32'(sys_oe),
              (codes[i] == INS_HIGHZ) ? 32'h0 : 32'hF);
        check(32'(sys_out), 32'h5);
      end
    end
  endtask

  task automatic t_boundary;
    @(posedge mclk);
    sys_in <= 4'hA;
    core_oe <= 4'hC;
    load_ir(INS_SAMPLE);
    bsp_ctrl_model_i.scan(1'b0, 12, 32'h396, d);
    settle;
    check(32'(d[11:0]), 32'hC5A);
    check(32'(sys_out), 32'h5);
    load_ir(INS_EXTEST);
    check(32'(sys_out), 32'h9);
    check(32'(sys_oe), 32'h3);
    load_ir(INS_INTEST);
    check(32'(core_in), 32'h6);
    load_ir(INS_BYPASS);
    check(32'(core_in), 32'hA);
  endtask

  task automatic t_reclaim;
    @(posedge mclk);
    pins_user <= 1'b1;
    user_out <= 4'hA;
    user_oe <= 4'h8;
    settle;
    bsp_ctrl_model_i.scan(1'b1, 5, 32'h0, d);
    settle;
    check(32'(test_active), 32'h0);
    check(32'(instr), 32'(INS_IDCODE));
    check(32'({pin_oe, pin_out}), 32'h8A);
    check(32'(user_in), 32'hE);
    check(32'(user_fb), 32'hA);
    @(posedge mclk);
    port_en <= 1'b1;
    settle;
    check(32'(test_active), 32'h1);
    check(32'(pin_oe), 32'h0);
    bsp_ctrl_model_i.reset_tap;
    load_ir(INS_BYPASS);
    check(32'(instr), 32'(INS_BYPASS));
    check(32'(user_fb), 32'hA);
    @(posedge mclk);
    port_en <= 1'b0;
    settle;
    check(32'(test_active), 32'h0);
    check(32'({pin_oe, pin_out}), 32'h8A);
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    port_en = 1'b0;
    pins_user = 1'b0;
    user_out = 4'h0;
    user_oe = 4'h0;
    sys_in = 4'h0;
    core_out = 4'h0;
    core_oe = 4'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    settle;
    t_reset;
    t_idcode;
    t_codes;
    t_boundary;
    t_reclaim;
    results;
  end

  // Whole run needs well under one millisecond
  initial begin
    #2000000;
    error_cnt++;
    results;
  end

endmodule

`default_nettype wire
